// ### truecolor_pixel_input_unpacker.sv
// Added by the designer: register access over Avalon-MM and the register offsets.
module truecolor_pixel_input_unpacker #(
	parameter int PAL_AW = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Avalon-MM slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Pixel input
	input wire logic blank_n_i,
	input wire logic [7:0] pix_byte_i,
	input wire logic [7:0] pix_byte_fall_i,
	// Converter outputs
	output logic [7:0] red_o,
	output logic [7:0] green_o,
	output logic [7:0] blue_o,
	output logic pix_valid_o
);

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	// Register bus
	logic rd_ack_q;
	logic [31:0] rdata_q;
	logic [2:0] unlock_cnt_q;
	logic [7:0] hidden_color_mode_reg_q;
	logic [7:0] mask_q;
	logic [7:0] pal_addr_q;
	logic [31:0] rd_mux;

	wire hit_mask = avs_address_i == pixel_unpack_pkg::MASK_OFS;
	wire hit_stat = avs_address_i == pixel_unpack_pkg::STAT_OFS;
	wire hit_paddr = avs_address_i == pixel_unpack_pkg::PAL_ADDR_OFS;
	wire hit_pdata = avs_address_i == pixel_unpack_pkg::PAL_DATA_OFS;
	wire unlocked = unlock_cnt_q == pixel_unpack_pkg::UNLOCK_READS;
	wire rd_done = avs_read_i & rd_ack_q;
	wire wr_lo = avs_write_i & avs_byteenable_i[0];
	wire wr_hidden = wr_lo & hit_mask & unlocked;
	wire wr_mask = wr_lo & hit_mask & ~unlocked;
	wire wr_paddr = wr_lo & hit_paddr;
	wire wr_pdata = wr_lo & hit_pdata;

	// Reads wait one cycle so read data always come from a flop
	assign avs_waitrequest_o = avs_read_i & ~rd_ack_q;
	assign avs_readdata_o = rdata_q;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rd_ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			rd_ack_q <= avs_read_i & ~rd_ack_q;
			if (avs_read_i & ~rd_ack_q) begin
				rdata_q <= rd_mux;
			end
		end
	end

	// Mask reads count up; any write or other access hides the register
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			unlock_cnt_q <= 3'h0;
		end else if (avs_write_i || (rd_done && !hit_mask)) begin
			unlock_cnt_q <= 3'h0;
		end else if (rd_done && !unlocked) begin
			unlock_cnt_q <= unlock_cnt_q + 3'h1;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			hidden_color_mode_reg_q <= pixel_unpack_pkg::HIDDEN_RST;
			mask_q <= pixel_unpack_pkg::MASK_RST;
			pal_addr_q <= pixel_unpack_pkg::PAL_ADDR_RST;
		end else begin
			if (wr_hidden) begin
				hidden_color_mode_reg_q <= avs_writedata_i[7:0];
			end
			if (wr_mask) begin
				mask_q <= avs_writedata_i[7:0];
			end
			if (wr_paddr) begin
				pal_addr_q <= avs_writedata_i[7:0];
			end else if (wr_pdata) begin
				pal_addr_q <= pal_addr_q + 8'h01;
			end
		end
	end

	// Mode decode
	pixel_unpack_pkg::color_mode_t mode_w;
	logic [4:0] code_w;
	logic ext_w;
	logic mix_w;

	assign code_w = hidden_color_mode_reg_q[4:0];
	assign ext_w = hidden_color_mode_reg_q[pixel_unpack_pkg::EXT_BIT]
		& hidden_color_mode_reg_q[pixel_unpack_pkg::EXT_BIT-1];

	// Unlisted codes fall back to palette mode
	always_comb begin
		mode_w = pixel_unpack_pkg::MODE_PAL8;
		if (ext_w) begin
			case (code_w)
				pixel_unpack_pkg::CODE_555: mode_w = pixel_unpack_pkg::MODE_555;
				pixel_unpack_pkg::CODE_MIX: mode_w = pixel_unpack_pkg::MODE_555;
				pixel_unpack_pkg::CODE_565: mode_w = pixel_unpack_pkg::MODE_565;
				pixel_unpack_pkg::CODE_888: mode_w = pixel_unpack_pkg::MODE_888;
				default: mode_w = pixel_unpack_pkg::MODE_PAL8;
			endcase
		end
	end

	assign mix_w = ext_w && code_w == pixel_unpack_pkg::CODE_MIX;
	wire is_888 = mode_w == pixel_unpack_pkg::MODE_888;
	wire is_16 = mode_w == pixel_unpack_pkg::MODE_555
		|| mode_w == pixel_unpack_pkg::MODE_565;
	// True color ignores the clocking bit and stays all-rising
	wire rise_only = hidden_color_mode_reg_q[pixel_unpack_pkg::CLKMODE_BIT]
		| is_888;

	pixel_unpack_pkg::byte_phase_t phase_q;

	assign rd_mux = hit_mask ? {24'h00_0000,
		unlocked ? hidden_color_mode_reg_q : mask_q} :
		hit_stat ? {24'h00_0000, phase_q, mode_w, mix_w, rise_only,
		unlocked, blank_n_i} :
		hit_paddr ? {24'h00_0000, pal_addr_q} : 32'h0000_0000;

	// Byte assembly
	pixel_unpack_pkg::byte_phase_t phase_d;
	logic [7:0] byte0_q;
	logic [7:0] byte1_q;
	logic done_w;
	logic [23:0] word_w;

	always_comb begin
		phase_d = pixel_unpack_pkg::PH_FIRST;
		done_w = 1'b0;
		if (blank_n_i) begin
			case (phase_q)
				pixel_unpack_pkg::PH_FIRST: begin
					if (is_888 || (is_16 && rise_only)) begin
						phase_d = pixel_unpack_pkg::PH_SECOND;
					end else begin
						done_w = 1'b1;
					end
				end
				pixel_unpack_pkg::PH_SECOND: begin
					if (is_888) begin
						phase_d = pixel_unpack_pkg::PH_THIRD;
					end else begin
						done_w = 1'b1;
					end
				end
				pixel_unpack_pkg::PH_THIRD: done_w = 1'b1;
				default: phase_d = pixel_unpack_pkg::PH_FIRST;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			phase_q <= pixel_unpack_pkg::PH_FIRST;
			byte0_q <= 8'h00;
			byte1_q <= 8'h00;
		end else begin
			phase_q <= phase_d;
			if (blank_n_i && phase_q == pixel_unpack_pkg::PH_FIRST) begin
				byte0_q <= pix_byte_i;
			end
			if (blank_n_i && phase_q == pixel_unpack_pkg::PH_SECOND) begin
				byte1_q <= pix_byte_i;
			end
		end
	end

	// Falling-edge high byte is presented on its own port in clocking mode 1
	wire [7:0] lo_w = rise_only ? byte0_q : pix_byte_i;
	wire [7:0] hi_w = rise_only ? pix_byte_i : pix_byte_fall_i;
	assign word_w = is_888 ? {pix_byte_i, byte1_q, byte0_q} :
		is_16 ? {8'h00, hi_w, lo_w} : {16'h0000, pix_byte_i};

	wire use_pal = mode_w == pixel_unpack_pkg::MODE_PAL8
		|| (mix_w && word_w[pixel_unpack_pkg::PIX_SEL_BIT]);
	wire [7:0] pal_idx = word_w[7:0] & mask_q;
	wire [23:0] dir_rgb = is_888 ? word_w :
		mode_w == pixel_unpack_pkg::MODE_565 ?
		{word_w[15:11], word_w[15:13], word_w[10:5], word_w[10:9],
		word_w[4:0], word_w[4:2]} :
		{word_w[14:10], word_w[14:12], word_w[9:5], word_w[9:7],
		word_w[4:0], word_w[4:2]};

	// Two-stage output aligns direct color with the palette read
	logic s1_valid_q;
	logic s1_pal_q;
	logic [23:0] s1_rgb_q;
	logic [23:0] pal_rdata;

	palette_ram #(
		.AW(PAL_AW),
		.DW(24)
	) u_palette (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.we_i(wr_pdata),
		.waddr_i(pal_addr_q[PAL_AW-1:0]),
		.wdata_i(avs_writedata_i[23:0]),
		.re_i(done_w & use_pal),
		.raddr_i(pal_idx[PAL_AW-1:0]),
		.rdata_o(pal_rdata)
	);

	wire [23:0] out_rgb = s1_pal_q ? pal_rdata : s1_rgb_q;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s1_valid_q <= 1'b0;
			s1_pal_q <= 1'b0;
			s1_rgb_q <= 24'h00_0000;
			pix_valid_o <= 1'b0;
			red_o <= 8'h00;
			green_o <= 8'h00;
			blue_o <= 8'h00;
		end else begin
			s1_valid_q <= done_w;
			s1_pal_q <= done_w & use_pal;
			s1_rgb_q <= dir_rgb;
			pix_valid_o <= s1_valid_q;
			if (s1_valid_q) begin
				red_o <= out_rgb[23:16];
				green_o <= out_rgb[15:8];
				blue_o <= out_rgb[7:0];
			end
		end
	end

	sequence s_two_stage;
		s1_valid_q ##1 pix_valid_o;
	endsequence

	a_blank_phase_clear: assert property (
		!blank_n_i |=> phase_q == pixel_unpack_pkg::PH_FIRST && !s1_valid_q)
		else $error("byte phase not cleared by blanking");

	a_first_byte_take: assert property (
		blank_n_i && phase_q == pixel_unpack_pkg::PH_FIRST
		|=> byte0_q == $past(pix_byte_i))
		else $error("first byte after blanking not captured");

	a_888_byte_walk: assert property (
		is_888 && blank_n_i && phase_q == pixel_unpack_pkg::PH_FIRST
		##1 blank_n_i ##1 blank_n_i |-> done_w)
		else $error("true color pixel not done on third byte");

	a_888_rgb_order: assert property (
		is_888 && done_w && $stable(hidden_color_mode_reg_q)
		|=> s_two_stage ##0 red_o == $past(pix_byte_i, 2)
		&& blue_o == $past(byte0_q, 2))
		else $error("true color byte order wrong");

	a_888_bypass_pal: assert property (
		is_888 && done_w |=> !s1_pal_q && s1_rgb_q[15:8] == $past(byte1_q))
		else $error("true color went through palette");

	a_mix_direct_path: assert property (
		mix_w && done_w && !word_w[15]
		|=> !s1_pal_q && s1_rgb_q[23:19] == $past(word_w[14:10]))
		else $error("mix direct pixel mis-decoded");

	a_mix_palette_path: assert property (
		mix_w && done_w && word_w[15] |=> s1_pal_q ##1 pix_valid_o)
		else $error("mix palette pixel not looked up");

	a_mode1_one_cycle: assert property (
		is_16 && !rise_only && blank_n_i
		|=> phase_q == pixel_unpack_pkg::PH_FIRST && s1_valid_q)
		else $error("clocking mode 1 pixel not taken in one cycle");

	a_hidden_locked: assert property (
		avs_write_i && hit_mask && !unlocked
		|=> $stable(hidden_color_mode_reg_q) && unlock_cnt_q == 3'h0)
		else $error("hidden register written while locked");

	a_hidden_hide: assert property (
		rd_done && !hit_mask |=> !unlocked [*2])
		else $error("other access did not hide register");

endmodule

// ### pixel_unpack_pkg.sv
package pixel_unpack_pkg;

	// Register byte offsets on the Avalon slave
	localparam logic [3:0] MASK_OFS = 4'h0;
	localparam logic [3:0] STAT_OFS = 4'h4;
	localparam logic [3:0] PAL_ADDR_OFS = 4'h8;
	localparam logic [3:0] PAL_DATA_OFS = 4'hC;

	// Values after reset
	localparam logic [7:0] HIDDEN_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'hFF;
	localparam logic [7:0] PAL_ADDR_RST = 8'h00;

	// Consecutive mask reads that expose the hidden color-mode register
	localparam logic [2:0] UNLOCK_READS = 3'h4;

	// Field positions in hidden_color_mode_reg and in a 16-bit pixel
	localparam int EXT_BIT = 7;
	localparam int CLKMODE_BIT = 5;
	localparam int MIX_BIT = 4;
	localparam int PIX_SEL_BIT = 15;

	// Low field codes of hidden_color_mode_reg, bits [4:0]
	localparam logic [4:0] CODE_555 = 5'h00;
	localparam logic [4:0] CODE_MIX = 5'h10;
	localparam logic [4:0] CODE_565 = 5'h01;
	localparam logic [4:0] CODE_888 = 5'h05;

	typedef enum logic [1:0] {
		MODE_PAL8 = 2'b00,
		MODE_555 = 2'b01,
		MODE_565 = 2'b10,
		MODE_888 = 2'b11
	} color_mode_t;

	typedef enum logic [1:0] {
		PH_FIRST = 2'b00,
		PH_SECOND = 2'b01,
		PH_THIRD = 2'b10
	} byte_phase_t;

endpackage

// ### palette_ram.sv
module palette_ram #(
	parameter int AW = 8,
	parameter int DW = 24
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Write port
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [DW-1:0] wdata_i,
	// Read port, data one cycle after re_i
	input wire logic re_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [DW-1:0] rdata_o
);

	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_o <= '0;
		end else if (re_i) begin
			rdata_o <= mem[raddr_i];
		end
	end

endmodule

// ### pixel_source.sv
module pixel_source (
	// Clock
	input wire logic clk_i,
	// Byte lane towards the unpacker
	output logic blank_n_o,
	output logic [7:0] byte_o,
	output logic [7:0] byte_fall_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		blank_n_o = 1'b0;
		byte_o = 8'hA5;
		byte_fall_o = 8'h5A;
	end

	// One byte pair is offered for exactly one rising edge
	task automatic push(input logic [7:0] lo, input logic [7:0] hi);
		@(posedge clk_i);
		blank_n_o <= 1'b1;
		byte_o <= lo;
		byte_fall_o <= hi;
	endtask

	// Blanked lines flip, so a stale byte can never pass as a good one
	task automatic idle();
		@(posedge clk_i);
		blank_n_o <= 1'b0;
		byte_o <= ~byte_o;
		byte_fall_o <= ~byte_fall_o;
	endtask
endmodule

// ### truecolor_pixel_input_unpacker_tb.sv
module truecolor_pixel_input_unpacker_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [3:0] address = 4'h0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic waitreq;
	logic blank_n;
	logic [7:0] pb;
	logic [7:0] pbf;
	logic [7:0] red;
	logic [7:0] green;
	logic [7:0] blue;
	logic valid;
	logic [23:0] pix_q[$];
	logic [31:0] d;
	logic [31:0] bus_rd;
	int fails = 0;
	int num_checks = 0;
	int cycles = 0;

	truecolor_pixel_input_unpacker u_truecolor_pixel_input_unpacker (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.avs_address_i(address), .avs_read_i(read), .avs_write_i(write),
		.avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
		.avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
		.blank_n_i(blank_n), .pix_byte_i(pb), .pix_byte_fall_i(pbf),
		.red_o(red), .green_o(green), .blue_o(blue), .pix_valid_o(valid)
	);

	pixel_source u_pixel_source (
		.clk_i(clk_i), .blank_n_o(blank_n), .byte_o(pb), .byte_fall_o(pbf)
	);

	initial begin
		forever #50 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cycles++;
		if (valid === 1'b1)
			pix_q.push_back({red, green, blue});
		if (cycles == 5000) begin
			fails++;
			end_sim();
		end
	end

	task automatic end_sim();
		if (fails == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic bus(input logic rw, input logic [3:0] a,
		input logic [31:0] wd);
		@(posedge clk_i);
		read <= ~rw;
		write <= rw;
		address <= a;
		wdata <= wd;
		// Judged at rising edges only; the bench timeout ends a hang
		do begin
			@(posedge clk_i);
		end while (waitreq !== 1'b0);
		bus_rd = rdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] data);
		bus(1'b0, a, 32'h0);
		data = bus_rd;
	endtask

	task automatic unlock();
		logic [31:0] x;
		repeat (4) rd(4'h0, x);
	endtask

	task automatic px(input logic [7:0] code, input logic [23:0] bytes,
		input int nb, input logic fall, input logic [23:0] exp);
		unlock();
		bus(1'b1, 4'h0, {24'h0, code});
		pix_q.delete();
		if (fall)
			u_pixel_source.push(bytes[7:0], bytes[15:8]);
		for (int i = 0; i < nb && !fall; i++)
			u_pixel_source.push(bytes[8*i +: 8], 8'h00);
		u_pixel_source.idle();
		// Answer latency is fixed at two cycles; eight leaves margin
		repeat (8) @(posedge clk_i);
		chk("pixel count", 32'd1, pix_q.size());
		if (pix_q.size() > 0)
			chk("pixel rgb", {8'h0, exp}, {8'h0, pix_q.pop_front()});
	endtask

	initial begin
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rd(4'h0, d);
		chk("mask", 32'hFF, d);
		repeat (3) rd(4'h0, d);
		rd(4'h0, d);
		chk("hidden reset", 32'h00, d);
		rd(4'h4, d);
		chk("status", 32'h02, d);
		rd(4'h0, d);
		chk("relocked mask", 32'hFF, d);
		rd(4'h2, d);
		chk("unmapped", 32'h0, d);
		bus(1'b1, 4'h0, 32'h7F);
		rd(4'h0, d);
		chk("mask written", 32'h7F, d);
		bus(1'b1, 4'h8, 32'h5A);
		bus(1'b1, 4'hC, 32'h123456);
		px(8'h00, 24'h00005A, 1, 1'b0, 24'h123456);
		px(8'hE2, 24'h0000DA, 1, 1'b0, 24'h123456);
		px(8'hE5, 24'h332211, 3, 1'b0, 24'h332211);
		px(8'hC5, 24'h332211, 3, 1'b0, 24'h332211);
		unlock();
		rd(4'h0, d);
		chk("hidden written", 32'hC5, d);
		px(8'hE0, 24'h004104, 2, 1'b0, 24'h844221);
		px(8'hE1, 24'h004104, 2, 1'b0, 24'h422021);
		px(8'hF0, 24'h004104, 2, 1'b0, 24'h844221);
		px(8'hF0, 24'h00FF5A, 2, 1'b0, 24'h123456);
		px(8'hD0, 24'h004104, 1, 1'b1, 24'h844221);
		px(8'hC1, 24'h004104, 1, 1'b1, 24'h422021);
		unlock();
		bus(1'b1, 4'h0, 32'hE5);
		pix_q.delete();
		u_pixel_source.push(8'h11, 8'h00);
		u_pixel_source.push(8'h22, 8'h00);
		u_pixel_source.idle();
		repeat (4) @(posedge clk_i);
		chk("partial dropped", 32'd0, pix_q.size());
		px(8'hE5, 24'h665544, 3, 1'b0, 24'h665544);
		end_sim();
	end
endmodule
